// [logic/pdd_parameter_ram_set_decoder.sv]
// Single-channel DMA engine driven by a parameter RAM behind APB
// Notes on behaviour
// - Option bit 23 picks 1D (0) or 2D (1) destination.
// - Destination mode 00 fixed, 01 increment, 10 decrement, 11 indexed.
// - Completion flag enable set: pending bit at code index on block end.
// - Four-bit completion code selects which pending bit is set.
// - Link enable: reload channel entry from link set at block end.
// - Frame sync bit: 0 element/array sync, 1 whole frame per event; in 2D the code moves the whole block per event.
// - Bits 14-13 extend code to six bits over low/high pending.
// - Alternate enable: set alternate pending bit after intermediate runs.
// - Six-bit alternate code picks the low or high pending bit.
// - Bit 3 peripheral read mode, bit 2 peripheral write mode.
// - Source and destination are 32-bit byte addresses, updated per mode.
// - Element count zero means no transfer at all.
// - Frame count holds frames minus one.
// - Element and frame indexes are signed 16-bit offsets.
// - Element index used only in 1D; 2D arrays are contiguous.
// - Frame index offsets one frame or array to the next.
// - 1D element sync reloads element count from reload value per frame.
// - Link field is the low 16 bits of a parameter RAM address.
// - Reload sets and unused entries serve as link targets; 85 available.
// - Source mode field bits 25-24 encoded like the destination one.
// - Option bit 26 picks 1D (0) or 2D (1) source.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/10ps
module pdd_parameter_ram_set_decoder
   import pdd_pkg::*;
#(
   parameter int NUM_SETS = DEF_SETS
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic [15:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic event_in,
   output logic xfer_valid_out,
   output logic [31:0] xfer_src_out,
   output logic [31:0] xfer_dst_out,
   output logic [1:0] xfer_size_out,
   output logic xfer_periph_rd_out,
   output logic xfer_periph_wr_out,
   input wire logic xfer_ready_in
);
   localparam int WORDS = NUM_SETS * SET_WORDS;
   localparam int WAW = $clog2(WORDS);

   // ****************************************
   // Storage and state
   // ****************************************
   logic [31:0] ram_q [WORDS];
   pdd_state_type st_q;
   logic [31:0] ctl_q, src_q, dst_q, asrc_q, adst_q;
   logic [15:0] ecnt_q, fcnt_q, eidx_q, fidx_q, erld_q, link_q, ecnt0_q;
   logic [2:0] wc_q;
   logic xv_q, evt_q, blk_q, pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic [63:0] pend_q;
   logic sy1_q, sy2_q, sy3_q;

   // ****************************************
   // Decode of the option word
   // ****************************************
   logic fsync, lnk_en, two_d, tc_en, atc_en;
   logic [1:0] dmode, sum;
   logic [5:0] tc_code, atc_code;
   logic [31:0] es, ei, fi;
   assign fsync = ctl_q[OB_FRAME_SYNC];
   assign lnk_en = ctl_q[OB_LINK];
   assign two_d = ctl_q[OB_DST_2D] | ctl_q[OB_SRC_2D];
   assign tc_en = ctl_q[OB_DONE_EN];
   assign atc_en = ctl_q[OB_ALT_EN];
   assign dmode = ctl_q[OB_DST_MODE_LO +: 2];
   assign sum = ctl_q[OB_SRC_MODE_LO +: 2];
   assign tc_code = {ctl_q[OB_CODE_HI_LO +: 2], ctl_q[OB_CODE_LO +: 4]};
   assign atc_code = ctl_q[OB_ALT_CODE_LO +: 6];
   assign ei = {{16{eidx_q[15]}}, eidx_q};
   assign fi = {{16{fidx_q[15]}}, fidx_q};
   // Step by element size; reserved size treated as byte
   assign es = (ctl_q[OB_SIZE_LO +: 2] == ESZ_WORD) ? STEP_WORD :
               (ctl_q[OB_SIZE_LO +: 2] == ESZ_HALF) ? STEP_HALF : STEP_BYTE;

   // Next address for one side after an element
   function automatic logic [31:0] nxt(input logic [31:0] a, input logic [31:0] s,
         input logic [1:0] m, input logic td, input logic fe,
         input logic [31:0] st, input logic [31:0] ix, input logic [31:0] fx);
      case (m)
         UPD_FIXED: nxt = a;
         UPD_INC: nxt = a + st;
         UPD_DEC: nxt = a - st;
         default: nxt = fe ? (td ? s + fx : a + fx) : (td ? a + st : a + ix);
      endcase
   endfunction

   // ****************************************
   // Transfer progress terms
   // ****************************************
   logic hs, fend, bend, run_end, eng_wr, fin_ev, mid_ev;
   assign hs = xv_q & xfer_ready_in;
   assign fend = hs & (ecnt_q == 16'h0001);
   assign bend = fend & (fcnt_q == 16'h0000);
   // Amount per event: element, array, frame or whole block
   assign run_end = bend | (fsync ? (fend & ~two_d) : (two_d ? fend : hs));
   assign eng_wr = (st_q == ST_WB) | (st_q == ST_LINK);
   assign fin_ev = (st_q == ST_WB) & (wc_q == 3'd2) & blk_q;
   assign mid_ev = (st_q == ST_WB) & (wc_q == 3'd2) & ~blk_q;

   // ****************************************
   // Event input synchroniser and trigger latch
   // ****************************************
   logic sw_evt, take;
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sy1_q <= 1'b0;
         sy2_q <= 1'b0;
         sy3_q <= 1'b0;
      end else begin
         sy1_q <= event_in;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
      end
   end

   // New edges win over the take so no event is lost
   assign take = (st_q == ST_IDLE) & evt_q;
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         evt_q <= 1'b0;
      end else begin
         evt_q <= (evt_q & ~take) | (sy2_q & ~sy3_q) | sw_evt;
      end
   end

   // ****************************************
   // APB slave, one wait state per access, more while the engine writes the RAM
   // ****************************************
   logic acc, in_ram, wr_ram;
   logic [13:0] widx;
   logic [31:0] rd;
   assign widx = paddr_in[15:2];
   assign in_ram = widx < 14'(WORDS);
   // Held off while the engine owns the RAM write port
   assign acc = psel_in & penable_in & ~pready_q & ~eng_wr;
   assign wr_ram = acc & pwrite_in & in_ram;
   assign sw_evt = acc & pwrite_in & (paddr_in == ADDR_EVT_SET) & pwdata_in[0];

   // Read mux; unmapped reads return zero
   always_comb begin
      rd = 32'h0000_0000;
      if (in_ram) begin
         rd = ram_q[widx[WAW-1:0]];
      end else if (paddr_in == ADDR_PEND_LO) begin
         rd = pend_q[31:0];
      end else if (paddr_in == ADDR_PEND_HI) begin
         rd = pend_q[63:32];
      end else if (paddr_in == ADDR_STATUS) begin
         rd = {28'h000_0000, blk_q, xv_q, evt_q, st_q != ST_IDLE};
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= acc;
         if (acc) begin
            prdata_q <= pwrite_in ? 32'h0000_0000 : rd;
            pslverr_q <= ~in_ram & (paddr_in != ADDR_PEND_LO) & (paddr_in != ADDR_PEND_HI) &
                         (paddr_in != ADDR_EVT_SET) & (paddr_in != ADDR_STATUS);
         end
      end
   end

   // ****************************************
   // Parameter RAM, engine writes take the port first
   // ****************************************
   logic [WAW-1:0] lbase, ewa;
   logic [31:0] ewd;
   assign lbase = link_q[WAW+1:2];
   always_comb begin
      ewa = WAW'(W_SRC);
      ewd = src_q;
      if (st_q == ST_LINK) begin
         ewa = WAW'(wc_q);
         ewd = ram_q[lbase + WAW'(wc_q)];
      end else if (wc_q == 3'd1) begin
         ewa = WAW'(W_CNT);
         ewd = {fcnt_q, ecnt_q};
      end else if (wc_q == 3'd2) begin
         ewa = WAW'(W_DST);
         ewd = dst_q;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (eng_wr) begin
         ram_q[ewa] <= ewd;
      end else if (wr_ram) begin
         ram_q[widx[WAW-1:0]] <= pwdata_in;
      end
   end

   // ****************************************
   // Completion pending bits, write one to clear
   // ****************************************
   logic [63:0] pset, pclr;
   always_comb begin
      pset = 64'h0000_0000_0000_0000;
      pclr = 64'h0000_0000_0000_0000;
      if (fin_ev && tc_en) begin
         pset[tc_code] = 1'b1;
      end
      if (mid_ev && atc_en) begin
         pset[atc_code] = 1'b1;
      end
      if (acc && pwrite_in && paddr_in == ADDR_PEND_LO) begin
         pclr[31:0] = pwdata_in;
      end
      if (acc && pwrite_in && paddr_in == ADDR_PEND_HI) begin
         pclr[63:32] = pwdata_in;
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pend_q <= 64'h0000_0000_0000_0000;
      end else begin
         pend_q <= (pend_q & ~pclr) | pset;
      end
   end

   // ****************************************
   // Engine sequencer
   // ****************************************
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= ST_IDLE;
         wc_q <= 3'd0;
         blk_q <= 1'b0;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               wc_q <= 3'd0;
               // Zero element count: event consumed, nothing moves
               if (evt_q && ram_q[W_CNT][15:0] != 16'h0000) begin
                  st_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (run_end) begin
                  st_q <= ST_WB;
                  blk_q <= bend;
               end
            end
            ST_WB: begin
               wc_q <= wc_q + 3'd1;
               if (wc_q == 3'd2) begin
                  wc_q <= 3'd0;
                  st_q <= (blk_q && lnk_en) ? ST_LINK : ST_IDLE;
               end
            end
            ST_LINK: begin
               wc_q <= wc_q + 3'd1;
               if (wc_q == 3'(SET_WORDS - 1)) begin
                  st_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ****************************************
   // Working copy of the channel entry
   // ****************************************
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctl_q <= 32'h0000_0000;
         src_q <= 32'h0000_0000;
         dst_q <= 32'h0000_0000;
         asrc_q <= 32'h0000_0000;
         adst_q <= 32'h0000_0000;
         ecnt_q <= 16'h0000;
         ecnt0_q <= 16'h0000;
         fcnt_q <= 16'h0000;
         eidx_q <= 16'h0000;
         fidx_q <= 16'h0000;
         erld_q <= 16'h0000;
         link_q <= 16'h0000;
      end else if (take) begin
         ctl_q <= ram_q[W_CTL];
         src_q <= ram_q[W_SRC];
         asrc_q <= ram_q[W_SRC];
         dst_q <= ram_q[W_DST];
         adst_q <= ram_q[W_DST];
         {fcnt_q, ecnt_q} <= ram_q[W_CNT];
         ecnt0_q <= ram_q[W_CNT][15:0];
         {fidx_q, eidx_q} <= ram_q[W_IDX];
         {erld_q, link_q} <= ram_q[W_LNK];
      end else if (hs) begin
         src_q <= nxt(src_q, asrc_q, sum, ctl_q[OB_SRC_2D], fend, es, ei, fi);
         dst_q <= nxt(dst_q, adst_q, dmode, ctl_q[OB_DST_2D], fend, es, ei, fi);
         if (fend) begin
            asrc_q <= nxt(src_q, asrc_q, sum, ctl_q[OB_SRC_2D], 1'b1, es, ei, fi);
            adst_q <= nxt(dst_q, adst_q, dmode, ctl_q[OB_DST_2D], 1'b1, es, ei, fi);
         end
         if (bend) begin
            ecnt_q <= 16'h0000;
         end else if (fend) begin
            fcnt_q <= fcnt_q - 16'h0001;
            ecnt_q <= (!two_d && !fsync) ? erld_q : ecnt0_q;
         end else begin
            ecnt_q <= ecnt_q - 16'h0001;
         end
      end
   end

   // ****************************************
   // Transfer request, held until accepted
   // ****************************************
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         xv_q <= 1'b0;
      end else if (hs) begin
         xv_q <= 1'b0;
      end else if (st_q == ST_RUN && ecnt_q != 16'h0000) begin
         xv_q <= 1'b1;
      end
   end

   assign xfer_valid_out = xv_q;
   assign xfer_src_out = src_q;
   assign xfer_dst_out = dst_q;
   assign xfer_size_out = ctl_q[OB_SIZE_LO +: 2];
   assign xfer_periph_rd_out = ctl_q[OB_PERIPH_RD];
   assign xfer_periph_wr_out = ctl_q[OB_PERIPH_WR];
   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;

   // ****************************************
   // Checks
   // ****************************************
   tc_pend_set_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (fin_ev && tc_en) |=> pend_q[$past(tc_code)])
      else $error("completion pending bit not set");
   alt_pend_set_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (mid_ev && atc_en) |=> pend_q[$past(atc_code)])
      else $error("alternate pending bit not set");
   link_start_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      fin_ev |=> (st_q == ST_LINK) == $past(lnk_en))
      else $error("link reload decision wrong");
   zero_count_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (take && ram_q[W_CNT][15:0] == 16'h0000) |=> (st_q == ST_IDLE) ##1 !xv_q)
      else $error("transfer started with zero count");
   dst_fixed_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (hs && dmode == UPD_FIXED) |=> dst_q == $past(dst_q))
      else $error("fixed destination moved");
   step_inc_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (hs && sum == UPD_INC) |=> src_q == $past(src_q) + $past(es))
      else $error("increment step wrong");
   elem_idx_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (hs && !fend && dmode == UPD_IDX && !ctl_q[OB_DST_2D]) |=> dst_q == $past(dst_q) + $past(ei))
      else $error("element index not applied");
   frame_idx_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (fend && dmode == UPD_IDX && !ctl_q[OB_DST_2D]) |=> dst_q == $past(dst_q) + $past(fi))
      else $error("frame index not applied");
   cnt_reload_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (fend && !bend && !two_d && !fsync) |=> ecnt_q == $past(erld_q))
      else $error("element count not reloaded");
endmodule

// [logic/pdd_pkg.sv]
// Constants and types for the DMA parameter set decoder
package pdd_pkg;
   // ****************************************
   // Option word field positions
   // ****************************************
   localparam int OB_FRAME_SYNC = 0;
   localparam int OB_LINK = 1;
   localparam int OB_PERIPH_WR = 2;
   localparam int OB_PERIPH_RD = 3;
   localparam int OB_ALT_CODE_LO = 5;
   localparam int OB_ALT_EN = 12;
   localparam int OB_CODE_HI_LO = 13;
   localparam int OB_CODE_LO = 16;
   localparam int OB_DONE_EN = 20;
   localparam int OB_DST_MODE_LO = 21;
   localparam int OB_DST_2D = 23;
   localparam int OB_SRC_MODE_LO = 24;
   localparam int OB_SRC_2D = 26;
   localparam int OB_SIZE_LO = 27;
   // ****************************************
   // Field encodings
   // ****************************************
   localparam logic [1:0] UPD_FIXED = 2'h0;
   localparam logic [1:0] UPD_INC = 2'h1;
   localparam logic [1:0] UPD_DEC = 2'h2;
   localparam logic [1:0] UPD_IDX = 2'h3;
   localparam logic [1:0] ESZ_WORD = 2'h0;
   localparam logic [1:0] ESZ_HALF = 2'h1;
   localparam logic [31:0] STEP_WORD = 32'h0000_0004;
   localparam logic [31:0] STEP_HALF = 32'h0000_0002;
   localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
   // ****************************************
   // Parameter set layout, in words
   // ****************************************
   localparam int SET_WORDS = 6;
   localparam int W_CTL = 0;
   localparam int W_SRC = 1;
   localparam int W_CNT = 2;
   localparam int W_DST = 3;
   localparam int W_IDX = 4;
   localparam int W_LNK = 5;
   localparam int DEF_SETS = 86;
   // ****************************************
   // Register map, byte addresses
   // ****************************************
   localparam logic [15:0] ADDR_PEND_LO = 16'h1000;
   localparam logic [15:0] ADDR_PEND_HI = 16'h1004;
   localparam logic [15:0] ADDR_EVT_SET = 16'h1008;
   localparam logic [15:0] ADDR_STATUS = 16'h100C;
   // Engine states, Gray along idle-run-writeback-link
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_WB = 2'b11,
      ST_LINK = 2'b10
   } pdd_state_type;
endpackage

// [tb/pdd_far_side.sv]
// Far-side memory and peripheral model answering element transfer requests
`timescale 1ns/10ps
module pdd_far_side (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic slow_in,
   input wire logic xfer_valid_in,
   input wire logic [31:0] xfer_src_in,
   input wire logic [31:0] xfer_dst_in,
   input wire logic [1:0] xfer_size_in,
   input wire logic xfer_periph_rd_in,
   input wire logic xfer_periph_wr_in,
   output logic xfer_ready_out
);
   logic [1:0] wait_q;
   logic [31:0] log_src[$];
   logic [31:0] log_dst[$];
   logic [3:0] log_attr[$];
   // Ready at once, or after a stall of three cycles per element
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wait_q <= 2'h0;
         xfer_ready_out <= 1'b0;
      end else if (!slow_in) begin
         wait_q <= 2'h0;
         xfer_ready_out <= 1'b1;
      end else if (xfer_valid_in && !xfer_ready_out) begin
         wait_q <= wait_q + 2'h1;
         xfer_ready_out <= (wait_q == 2'h2);
      end else begin
         wait_q <= 2'h0;
         xfer_ready_out <= 1'b0;
      end
   end
   // Log each accepted element; only the handshake edge counts
   always @(posedge mclk_in) begin
      if (rst_n_in && xfer_valid_in && xfer_ready_out) begin
         log_src.push_back(xfer_src_in);
         log_dst.push_back(xfer_dst_in);
         log_attr.push_back({xfer_size_in, xfer_periph_rd_in, xfer_periph_wr_in});
      end
   end
endmodule

// [tb/tb.sv]
// Self-checking bench for the parameter set decoder
`timescale 1ns/10ps
module tb;
   import pdd_pkg::*;
   logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, evt, xvalid, xrd, xwr, xready, slow, last_e;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, xsrc, xdst;
   logic [1:0] xsize;
   int bad_count, n_tests;
   // ****************************************
   // Design and far side
   // ****************************************
   pdd_parameter_ram_set_decoder dut_u (.mclk_in(mclk), .rst_n_in(rst_n), .paddr_in(paddr), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .event_in(evt), .xfer_valid_out(xvalid),
      .xfer_src_out(xsrc), .xfer_dst_out(xdst), .xfer_size_out(xsize), .xfer_periph_rd_out(xrd),
      .xfer_periph_wr_out(xwr), .xfer_ready_in(xready));
   pdd_far_side part_u (.mclk_in(mclk), .rst_n_in(rst_n), .slow_in(slow), .xfer_valid_in(xvalid),
      .xfer_src_in(xsrc), .xfer_dst_in(xdst), .xfer_size_in(xsize), .xfer_periph_rd_in(xrd),
      .xfer_periph_wr_in(xwr), .xfer_ready_out(xready));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r);
      int i;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      r = prdata;
      last_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         bad_count++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rd_chk(input string what, input logic [15:0] a, input logic [31:0] exp);
      logic [31:0] r;
      apb(1'b0, a, 32'h0000_0000, r);
      chk(what, r, exp);
   endtask
   // Bounded wait until status shows no busy, latched event or request
   task automatic wait_idle();
      logic [31:0] r;
      int i;
      repeat (6) @(posedge mclk);
      i = 0;
      do begin
         apb(1'b0, ADDR_STATUS, 32'h0000_0000, r);
         i++;
      end while ((r & 32'h0000_0007) !== 32'h0000_0000 && i < 40);
      if ((r & 32'h0000_0007) !== 32'h0000_0000) begin
         bad_count++;
         stop_test();
      end
   endtask
   task automatic pulse_pin();
      @(posedge mclk);
      evt <= 1'b1;
      repeat (4) @(posedge mclk);
      evt <= 1'b0;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_regs();
      rd_chk("unmapped read", 16'h2000, 32'h0000_0000);
      chk("unmapped error", {31'h0000_0000, last_e}, 32'h0000_0001);
      rd_chk("event set read", ADDR_EVT_SET, 32'h0000_0000);
      wr(16'h0004, 32'hA5A5_0001);
      rd_chk("source word", 16'h0004, 32'hA5A5_0001);
      chk("ram error", {31'h0000_0000, last_e}, 32'h0000_0000);
      $display("test regs done");
   endtask
   // Frame sync 1D block, source increments by word, stalling far side
   task automatic test_frame_sync();
      int b;
      b = part_u.log_src.size();
      slow <= 1'b1;
      wr(16'h0000, 32'h0115_4009);
      wr(16'h0004, 32'h2000_0000);
      wr(16'h0008, 32'h0000_0003);
      wr(16'h000C, 32'h3000_0010);
      wr(16'h0010, 32'h0000_0000);
      wr(16'h0014, 32'h0000_0000);
      rd_chk("option word", 16'h0000, 32'h0115_4009);
      wr(ADDR_EVT_SET, 32'h0000_0001);
      wait_idle();
      chk("frame requests", 32'(part_u.log_src.size() - b), 32'h0000_0003);
      for (int i = 0; i < 3; i++) begin
         chk("frame src", part_u.log_src[b + i], 32'h2000_0000 + 32'(4 * i));
         chk("frame dst", part_u.log_dst[b + i], 32'h3000_0010);
         chk("frame attr", {28'h000_0000, part_u.log_attr[b + i]}, 32'h0000_0002);
      end
      rd_chk("pending high", ADDR_PEND_HI, 32'h0000_0020);
      rd_chk("pending low", ADDR_PEND_LO, 32'h0000_0000);
      wr(ADDR_PEND_HI, 32'h0000_0020);
      rd_chk("pending cleared", ADDR_PEND_HI, 32'h0000_0000);
      $display("test frame_sync done");
   endtask
   // 2D indexed destination, two arrays by pin, alternate flag, then link
   task automatic test_two_dim_link();
      int b;
      b = part_u.log_src.size();
      slow <= 1'b0;
      wr(16'h0000, 32'h08E0_1426);
      wr(16'h0004, 32'h1000_0000);
      wr(16'h0008, 32'h0001_0002);
      wr(16'h000C, 32'h4000_0000);
      wr(16'h0010, 32'h0100_0008);
      wr(16'h0014, 32'h0000_0018);
      wr(16'h0018, 32'h0000_0001);
      wr(16'h001C, 32'h5555_0000);
      for (int i = 8; i < 12; i++) begin
         wr(16'(4 * i), 32'h0000_0000);
      end
      pulse_pin();
      wait_idle();
      chk("first array", 32'(part_u.log_src.size() - b), 32'h0000_0002);
      rd_chk("alt pending high", ADDR_PEND_HI, 32'h0000_0002);
      rd_chk("alt pending low", ADDR_PEND_LO, 32'h0000_0000);
      wr(ADDR_PEND_HI, 32'h0000_0002);
      pulse_pin();
      wait_idle();
      chk("all arrays", 32'(part_u.log_src.size() - b), 32'h0000_0004);
      for (int i = 0; i < 4; i++) begin
         chk("array dst", part_u.log_dst[b + i], 32'h4000_0000 + 32'((i / 2) * 256 + (i % 2) * 2));
         chk("array src", part_u.log_src[b + i], 32'h1000_0000);
         chk("array attr", {28'h000_0000, part_u.log_attr[b + i]}, 32'h0000_0005);
      end
      rd_chk("end pending high", ADDR_PEND_HI, 32'h0000_0000);
      rd_chk("end pending low", ADDR_PEND_LO, 32'h0000_0000);
      rd_chk("linked option", 16'h0000, 32'h0000_0001);
      rd_chk("linked source", 16'h0004, 32'h5555_0000);
      $display("test two_dim_link done");
   endtask
   // Linked entry has element count zero: event gives no request
   task automatic test_zero_count();
      int b;
      b = part_u.log_src.size();
      wr(ADDR_EVT_SET, 32'h0000_0001);
      wait_idle();
      chk("zero count requests", 32'(part_u.log_src.size() - b), 32'h0000_0000);
      $display("test zero_count done");
   endtask
   // 1D element sync: indexed byte destination, decrementing source, count reload
   task automatic test_one_dim_index();
      int b;
      logic [31:0] ed [4];
      b = part_u.log_src.size();
      ed = '{32'h6000_0100, 32'h6000_00FC, 32'h6000_010C, 32'h6000_0108};
      wr(16'h0000, 32'h1273_0000);
      wr(16'h0004, 32'h7000_0010);
      wr(16'h0008, 32'h0001_0002);
      wr(16'h000C, 32'h6000_0100);
      wr(16'h0010, 32'h0010_FFFC);
      wr(16'h0014, 32'h0002_0000);
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_EVT_SET, 32'h0000_0001);
         wait_idle();
         chk("element requests", 32'(part_u.log_src.size() - b), 32'(i + 1));
         if (i == 1) begin
            rd_chk("reloaded count", 16'h0008, 32'h0000_0002);
         end
      end
      for (int i = 0; i < 4; i++) begin
         chk("indexed dst", part_u.log_dst[b + i], ed[i]);
         chk("dec src", part_u.log_src[b + i], 32'h7000_0010 - 32'(i));
         chk("byte attr", {28'h000_0000, part_u.log_attr[b + i]}, 32'h0000_0008);
      end
      rd_chk("done pending low", ADDR_PEND_LO, 32'h0000_0008);
      $display("test one_dim_index done");
   endtask
   // ****************************************
   // Clock and main sequence
   // ****************************************
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0000_0000;
      evt = 1'b0;
      slow = 1'b0;
      bad_count = 0;
      n_tests = 0;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      test_regs();
      test_frame_sync();
      test_two_dim_link();
      test_zero_count();
      test_one_dim_index();
      stop_test();
   end
endmodule
